// ### design/adc_power_conversion_control.sv
// Power state, wakeup and start command control with its serial register port
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"

module adc_power_conversion_control (
  input  wire logic       clk,
  input  wire logic       ce,
  input  wire logic       rstn,
  input  wire logic       sclk,
  input  wire logic       csb,
  input  wire logic       sdi,
  output logic            sdo,
  input  wire logic       conv_busy,
  input  wire logic       cal_busy,
  input  wire logic       seq_jump,
  input  wire logic [6:0] seq_jump_addr,
  input  wire logic       seq_finished,
  output logic [1:0]      power_state,
  output logic            analog_en,
  output logic            regulator_en,
  output logic            conv_go,
  output logic [2:0]      result_slot_select,
  output logic [1:0]      conversion_kind,
  output logic            seq_go,
  output logic [6:0]      sequence_entry_address,
  output logic            seq_running,
  output logic            sequence_done_flag,
  output logic            cal_go,
  output logic [2:0]      cal_type,
  output logic            delay_go,
  output logic            op_abort
);

  // Writable bits per register; everything else stays zero
  function automatic logic [7:0] field_mask(input logic [6:0] a);
    unique case (a)
      `OFS_POWER_STATE_SELECT:  field_mask = 8'h03;
      `OFS_CONVERSION_TRIGGER:  field_mask = 8'h73;
      `OFS_SEQUENCE_LAUNCH:     field_mask = 8'h7f;
      `OFS_CALIBRATION_TRIGGER: field_mask = 8'h07;
      `OFS_PIN0_SETUP:          field_mask = 8'hf7;
      `OFS_PIN1_SETUP:          field_mask = 8'hf7;
      `OFS_PIN_CONV_SETUP:      field_mask = 8'h73;
      `OFS_PIN_SEQ_ADDRESS:     field_mask = 8'h7f;
      `OFS_FILTER_SETUP:        field_mask = 8'h3f;
      `OFS_AMP_GAIN:            field_mask = 8'h37;
      `OFS_DELAY_LAUNCH:        field_mask = 8'h00;
      default:                  field_mask = (a <= `REG_LAST) ? 8'hff : 8'h00;
    endcase
  endfunction

  // Start command registers and their kinds
  function automatic logic is_start(input logic [6:0] a);
    is_start = (a == `OFS_CONVERSION_TRIGGER) || (a == `OFS_SEQUENCE_LAUNCH) ||
               (a == `OFS_CALIBRATION_TRIGGER) || (a == `OFS_DELAY_LAUNCH);
  endfunction

  function automatic adc_ctrl_pkg::cmd_kind_e kind_of(input logic [6:0] a);
    if (a == `OFS_CONVERSION_TRIGGER) begin
      kind_of = adc_ctrl_pkg::CMD_CONV;
    end else if (a == `OFS_SEQUENCE_LAUNCH) begin
      kind_of = adc_ctrl_pkg::CMD_SEQ;
    end else if (a == `OFS_CALIBRATION_TRIGGER) begin
      kind_of = adc_ctrl_pkg::CMD_CAL;
    end else begin
      kind_of = adc_ctrl_pkg::CMD_DELAY;
    end
  endfunction

  localparam logic [7:0] WAKE_LOAD = 8'(`WAKE_CYCLES - 1);

  // Link domain state
  logic [4:0]              bit_cnt_r;
  logic [15:0]             shift_r;
  logic [7:0]              rd_shift_r;
  adc_ctrl_pkg::spi_word_s wr_hold_r;
  logic                    wr_tog_r;

  // Core domain state
  logic [7:0]              regs_r [0:`REG_COUNT-1];
  logic [7:0]              img_r  [0:`REG_COUNT-1];
  logic                    csb_s1_r, csb_s2_r, csb_s3_r, csb_q_r;
  logic                    tog_s1_r, tog_s2_r, tog_s3_r, tog_q_r;
  adc_ctrl_pkg::wake_state_e wk_state_r;
  logic [7:0]              wake_cnt_r;
  logic                    pend_v_r;
  adc_ctrl_pkg::start_cmd_s pend_r;

  // Decoded write event
  logic                    wr_ev;
  logic [6:0]              wr_addr;
  logic [7:0]              wr_data;
  logic                    seq_ok;
  logic                    valid_cmd;
  logic                    waking;
  logic                    wake_fire;
  logic                    defer;
  logic                    now_go;
  logic                    pd_wr;
  logic                    soft_rst;
  logic                    launch;
  adc_ctrl_pkg::start_cmd_s launch_cmd;

  // Link side: bit counter and input shifter, cleared while the frame is idle
  always_ff @(posedge sclk or posedge csb) begin
    if (csb) begin
      bit_cnt_r <= 5'h00;
      shift_r   <= 16'h0000;
    end else begin
      if (bit_cnt_r != 5'h10) begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
      shift_r <= {shift_r[14:0], sdi};
    end
  end

  // Link side: a write completes on the 16th rising edge and toggles the handshake
  always_ff @(posedge sclk or negedge rstn) begin
    if (!rstn) begin
      wr_hold_r <= '0;
      wr_tog_r  <= 1'b0;
    end else if (bit_cnt_r == 5'h0f && !shift_r[14]) begin
      wr_hold_r <= '{addr: shift_r[13:7], data: {shift_r[6:0], sdi}};
      wr_tog_r  <= ~wr_tog_r;
    end
  end

  // Link side: read data leaves MSB first from the 8th falling edge
  always_ff @(negedge sclk or posedge csb) begin
    if (csb) begin
      rd_shift_r <= 8'h00;
      sdo        <= 1'b0;
    end else if (bit_cnt_r == 5'h08 && shift_r[7]) begin
      rd_shift_r <= (shift_r[6:0] <= `REG_LAST) ? {img_r[shift_r[4:0]][6:0], 1'b0} : 8'h00;
      sdo        <= (shift_r[6:0] <= `REG_LAST) ? img_r[shift_r[4:0]][7] : 1'b0;
    end else if (bit_cnt_r > 5'h08) begin
      rd_shift_r <= {rd_shift_r[6:0], 1'b0};
      sdo        <= rd_shift_r[7];
    end
  end

  // Frame select and write toggle crossing into the core clock
  always_ff @(posedge clk) begin
    if (!rstn) begin
      csb_s1_r <= 1'b1;
      csb_s2_r <= 1'b1;
      csb_s3_r <= 1'b1;
      csb_q_r  <= 1'b1;
      tog_s1_r <= 1'b0;
      tog_s2_r <= 1'b0;
      tog_s3_r <= 1'b0;
      tog_q_r  <= 1'b0;
    end else if (ce) begin
      csb_s1_r <= csb;
      csb_s2_r <= csb_s1_r;
      csb_s3_r <= csb_s2_r;
      tog_s1_r <= wr_tog_r;
      tog_s2_r <= tog_s1_r;
      tog_s3_r <= tog_s2_r;
      if (csb_s2_r == csb_s3_r) begin
        csb_q_r <= csb_s3_r;
      end
      if (tog_s2_r == tog_s3_r) begin
        tog_q_r <= tog_s3_r;
      end
    end
  end

  // Write decode, wakeup deferral and launch selection
  always_comb begin
    wr_ev      = ce && (tog_s2_r == tog_s3_r) && (tog_s3_r != tog_q_r);
    wr_addr    = wr_hold_r.addr;
    wr_data    = wr_hold_r.data & field_mask(wr_hold_r.addr);
    seq_ok     = (wr_data[6:0] >= `SEQUENCE_ENTRY_ADDRESS_MIN) && (wr_data[6:0] <= `SEQUENCE_ENTRY_ADDRESS_MAX);
    valid_cmd  = wr_ev && is_start(wr_addr) && (wr_addr != `OFS_SEQUENCE_LAUNCH || seq_ok);
    waking     = (wk_state_r == adc_ctrl_pkg::WK_BUSY);
    wake_fire  = ce && waking && (wake_cnt_r == 8'h00);
    defer      = valid_cmd && (regs_r[0][1:0] != `PD_NORMAL || waking);
    now_go     = valid_cmd && !defer;
    pd_wr      = wr_ev && (wr_addr == `OFS_POWER_STATE_SELECT);
    soft_rst   = pd_wr && (wr_data[1:0] == `PD_RESET);
    launch     = now_go || (wake_fire && !pd_wr && (pend_v_r || defer));
    launch_cmd = (valid_cmd) ? '{kind: kind_of(wr_addr), data: wr_data} : pend_r;
  end

  // Register file, with power field moves for wakeup and self-clearing reset
  always_ff @(posedge clk) begin
    if (!rstn || (ce && soft_rst)) begin
      regs_r[0] <= `RST_POWER_STATE_SELECT;
      for (int i = 1; i < `REG_COUNT; i++) begin
        regs_r[i] <= `RST_OTHER;
      end
    end else if (ce) begin
      if (wr_ev && wr_addr <= `REG_LAST) begin
        regs_r[wr_addr[4:0]] <= wr_data;
      end
      if (defer && !waking) begin
        regs_r[0] <= {6'h00, `PD_SLEEP};
      end else if (wake_fire && !pd_wr) begin
        regs_r[0] <= {6'h00, `PD_NORMAL};
      end
    end
  end

  // Read image, frozen while a frame is in progress
  always_ff @(posedge clk) begin
    if (!rstn) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        img_r[i] <= 8'h00;
      end
    end else if (ce && csb_q_r) begin
      for (int i = 0; i < `REG_COUNT; i++) begin
        img_r[i] <= regs_r[i];
      end
    end
  end

  // Wakeup timer and the single pending start command
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wk_state_r <= adc_ctrl_pkg::WK_IDLE;
      wake_cnt_r <= 8'h00;
      pend_v_r   <= 1'b0;
      pend_r     <= '0;
    end else if (ce) begin
      if (pd_wr) begin
        wk_state_r <= adc_ctrl_pkg::WK_IDLE;
        pend_v_r   <= 1'b0;
      end else begin
        unique case (wk_state_r)
          adc_ctrl_pkg::WK_IDLE: begin
            if (defer) begin
              wk_state_r <= adc_ctrl_pkg::WK_BUSY;
              wake_cnt_r <= WAKE_LOAD;
              pend_v_r   <= 1'b1;
              pend_r     <= launch_cmd;
            end
          end
          adc_ctrl_pkg::WK_BUSY: begin
            if (wake_cnt_r == 8'h00) begin
              wk_state_r <= adc_ctrl_pkg::WK_IDLE;
              pend_v_r   <= 1'b0;
            end else begin
              wake_cnt_r <= wake_cnt_r - 8'h01;
              if (defer) begin
                pend_r <= launch_cmd;
              end
            end
          end
        endcase
      end
    end
  end

  // Start pulses, command fields and sequencer run state
  always_ff @(posedge clk) begin
    if (!rstn) begin
      conv_go                <= 1'b0;
      seq_go                 <= 1'b0;
      cal_go                 <= 1'b0;
      delay_go               <= 1'b0;
      result_slot_select     <= 3'h0;
      conversion_kind        <= 2'h0;
      sequence_entry_address <= 7'h00;
      cal_type               <= 3'h0;
      seq_running            <= 1'b0;
      sequence_done_flag     <= 1'b0;
    end else if (ce) begin
      conv_go            <= 1'b0;
      seq_go             <= 1'b0;
      cal_go             <= 1'b0;
      delay_go           <= 1'b0;
      sequence_done_flag <= 1'b0;
      if (seq_finished) begin
        seq_running        <= 1'b0;
        sequence_done_flag <= seq_running;
      end
      if (launch) begin
        unique case (launch_cmd.kind)
          adc_ctrl_pkg::CMD_CONV: begin
            conv_go            <= 1'b1;
            result_slot_select <= launch_cmd.data[`SLOT_MSB:`SLOT_LSB];
            conversion_kind    <= launch_cmd.data[`KIND_MSB:`KIND_LSB];
          end
          adc_ctrl_pkg::CMD_SEQ: begin
            seq_go                 <= 1'b1;
            sequence_entry_address <= launch_cmd.data[`ADDR_MSB:`ADDR_LSB];
            seq_running            <= 1'b1;
          end
          adc_ctrl_pkg::CMD_CAL: begin
            cal_go   <= 1'b1;
            cal_type <= launch_cmd.data[`CAL_MSB:`CAL_LSB];
          end
          adc_ctrl_pkg::CMD_DELAY: begin
            delay_go <= 1'b1;
          end
        endcase
      end else if (seq_jump && seq_running) begin
        seq_go                 <= 1'b1;
        sequence_entry_address <= seq_jump_addr;
        seq_running            <= 1'b1;
      end
      if (pd_wr && wr_data[1:0] != `PD_NORMAL && seq_running) begin
        seq_running        <= 1'b0;
        sequence_done_flag <= 1'b1;
      end
    end
  end

  // Power outputs follow the power field; analog stays up during wakeup
  always_ff @(posedge clk) begin
    if (!rstn) begin
      power_state  <= `PD_SLEEP;
      analog_en    <= 1'b0;
      regulator_en <= 1'b0;
    end else if (ce) begin
      power_state  <= regs_r[0][1:0];
      analog_en    <= (regs_r[0][1:0] == `PD_NORMAL) || waking;
      regulator_en <= (regs_r[0][1:0] != `PD_SLEEP) || waking;
    end
  end

  // Any register write while converting or calibrating aborts that activity
  always_ff @(posedge clk) begin
    if (!rstn) begin
      op_abort <= 1'b0;
    end else if (ce) begin
      op_abort <= wr_ev && (conv_busy || cal_busy);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn || !ce);

  a_reset_sleep_code: assert property (@(posedge clk) disable iff (1'b0) !rstn |=> power_state == 2'h2)
    else $error("power state not sleep after reset");
  a_soft_reset_clears: assert property (soft_rst |=> regs_r[0] == 8'h02 && regs_r[1] == 8'h00)
    else $error("reset code did not restore registers");
  a_wake_reads_sleep: assert property (waking |-> regs_r[0][1:0] == 2'h2)
    else $error("power field not 10 during wakeup");
  a_wake_end_normal: assert property (wake_fire && !pd_wr |=> regs_r[0][1:0] == 2'h0 ##1 power_state == 2'h0)
    else $error("power field not normal after wakeup");
  a_wake_holds_start: assert property (waking && wake_cnt_r != 8'h00 |=> !(conv_go || seq_go || cal_go || delay_go))
    else $error("start issued before wakeup end");
  a_pending_fires_once: assert property (wake_fire && pend_v_r && !pd_wr |=> (conv_go || seq_go || cal_go || delay_go)
                                         ##1 !pend_v_r)
    else $error("pending start not issued once");
  a_seq_range_drop: assert property (wr_ev && wr_addr == 7'h02 && !seq_ok && !seq_jump && !wake_fire |=> !seq_go)
    else $error("out of range launch started");
  a_seq_launch_addr: assert property (now_go && wr_addr == 7'h02 |=> seq_go && seq_running
                                      && sequence_entry_address == $past(wr_data[6:0]))
    else $error("launch address wrong");
  a_conv_fields: assert property (now_go && wr_addr == 7'h01 |=> conv_go && result_slot_select == $past(wr_data[6:4])
                                  && conversion_kind == $past(wr_data[1:0]))
    else $error("conversion fields wrong");
  a_pd_halts_seq: assert property (pd_wr && wr_data[1:0] != 2'h0 && seq_running |=> sequence_done_flag && !seq_running)
    else $error("power down did not halt sequence");
  a_jump_continues: assert property (seq_jump && seq_running && !launch && !pd_wr |=> seq_go && seq_running
                                     && sequence_entry_address == $past(seq_jump_addr))
    else $error("sequencer jump not taken");
  a_write_aborts: assert property (wr_ev && conv_busy |=> op_abort)
    else $error("write did not abort conversion");

  c_wake_then_conv: cover property (defer && wr_addr == 7'h01 ##[1:40] conv_go);
  c_seq_jump: cover property (seq_running && seq_jump);
  c_soft_reset: cover property (soft_rst);
  c_abort: cover property (op_abort);

endmodule

// ### inc/adc_ctrl_pkg.sv
// Types shared by the converter power and conversion control block
package adc_ctrl_pkg;

  // Wakeup sequencer states, one-hot
  typedef enum logic [1:0] {
    WK_IDLE = 2'b01,
    WK_BUSY = 2'b10
  } wake_state_e;

  // Kind of asynchronous start command
  typedef enum logic [1:0] {
    CMD_CONV  = 2'h0,
    CMD_SEQ   = 2'h1,
    CMD_CAL   = 2'h2,
    CMD_DELAY = 2'h3
  } cmd_kind_e;

  // Serial write word handed from the link domain
  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } spi_word_s;

  // Start command held during wakeup
  typedef struct packed {
    cmd_kind_e  kind;
    logic [7:0] data;
  } start_cmd_s;

endpackage

// ### inc/adc_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the control block
`ifndef ADC_CTRL_REGS_SVH
`define ADC_CTRL_REGS_SVH

// Register offsets (8-bit control map)
`define OFS_POWER_STATE_SELECT   7'h00
`define OFS_CONVERSION_TRIGGER   7'h01
`define OFS_SEQUENCE_LAUNCH      7'h02
`define OFS_CALIBRATION_TRIGGER  7'h03
`define OFS_PIN0_SETUP           7'h04
`define OFS_PIN1_SETUP           7'h05
`define OFS_PIN_CONV_SETUP       7'h06
`define OFS_PIN_SEQ_ADDRESS      7'h07
`define OFS_FILTER_SETUP         7'h08
`define OFS_REF_CLK_FMT_SETUP    7'h09
`define OFS_EXCITATION_SETUP     7'h0a
`define OFS_INPUT_MUX            7'h0b
`define OFS_CURRENT_MUX          7'h0c
`define OFS_BIAS_MUX             7'h0d
`define OFS_AMP_GAIN             7'h0e
`define OFS_DELAY_EXTENSION      7'h0f
`define OFS_DELAY_LAUNCH         7'h10
`define REG_COUNT                17
`define REG_LAST                 7'h10

// Power state codes
`define PD_NORMAL                2'h0
`define PD_STANDBY               2'h1
`define PD_SLEEP                 2'h2
`define PD_RESET                 2'h3

// Field positions
`define PD_MSB                   1
`define PD_LSB                   0
`define SLOT_MSB                 6
`define SLOT_LSB                 4
`define KIND_MSB                 1
`define KIND_LSB                 0
`define ADDR_MSB                 6
`define ADDR_LSB                 0
`define CAL_MSB                  2
`define CAL_LSB                  0

// Reset values
`define RST_POWER_STATE_SELECT   8'h02
`define RST_OTHER                8'h00

// Sequencer microcode window
`define SEQUENCE_ENTRY_ADDRESS_MIN             7'h3a
`define SEQUENCE_ENTRY_ADDRESS_MAX             7'h6e

// Timing: wakeup time in ns and clock rate in MHz, cycles rounded up
`define CLK_MHZ                  25
`define WAKE_TIME_NS             1000
`define WAKE_CYCLES              ((`WAKE_TIME_NS * `CLK_MHZ + 999) / 1000)

`endif

// ### tb/adc_power_conversion_control_tb_top.sv
// Self-checking bench for the power state, wakeup and start command control block
`timescale 1ns/1ps
`include "adc_ctrl_regs.svh"
module adc_power_conversion_control_tb_top;
  logic       clk, rstn, ce, conv_busy, cal_busy, seq_jump, seq_finished;
  logic [6:0] seq_jump_addr;
  logic       sclk, csb, sdi, sdo;
  logic [1:0] power_state, conversion_kind;
  logic       analog_en, regulator_en, conv_go, seq_go, seq_running, sequence_done_flag;
  logic       cal_go, delay_go, op_abort;
  logic [2:0] result_slot_select, cal_type;
  logic [6:0] sequence_entry_address;
  logic [7:0] q;
  int         mismatches, checks, n;

  adc_power_conversion_control u_dut (
    .clk(clk), .ce(ce), .rstn(rstn), .sclk(sclk), .csb(csb), .sdi(sdi), .sdo(sdo),
    .conv_busy(conv_busy), .cal_busy(cal_busy), .seq_jump(seq_jump), .seq_jump_addr(seq_jump_addr),
    .seq_finished(seq_finished), .power_state(power_state), .analog_en(analog_en),
    .regulator_en(regulator_en), .conv_go(conv_go), .result_slot_select(result_slot_select),
    .conversion_kind(conversion_kind), .seq_go(seq_go), .sequence_entry_address(sequence_entry_address),
    .seq_running(seq_running), .sequence_done_flag(sequence_done_flag), .cal_go(cal_go),
    .cal_type(cal_type), .delay_go(delay_go), .op_abort(op_abort));

  spi_host_model u_host (.sclk(sclk), .csb(csb), .sdi(sdi), .sdo(sdo));

  // Core clock, 25 MHz
  initial clk = 1'b0;
  always #20 clk = ~clk;

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
    checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    u_host.xfer(1'b0, a, d, q);
  endtask

  task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp, input string what);
    u_host.xfer(1'b1, a, 8'h00, q);
    check(q, exp, what);
  endtask

  // Event pulses watched by the wait helper
  function automatic logic pick(input int k);
    case (k)
      0: pick = conv_go;
      1: pick = seq_go;
      2: pick = sequence_done_flag;
      3: pick = op_abort;
      4: pick = cal_go;
      default: pick = delay_go;
    endcase
  endfunction

  // Cycles until the chosen pulse, or -1 when it never comes within the limit
  task automatic wait_ev(input int k, input int lim, output int cyc);
    for (cyc = 0; cyc < lim; cyc++) begin
      @(negedge clk);
      if (pick(k) === 1'b1) return;
    end
    cyc = -1;
  endtask

  task automatic t_reset_values();
    check({6'h0, power_state}, 8'h02, "power after reset");
    check({6'h0, analog_en, regulator_en}, 8'h00, "sleep enables");
    rd_chk(`OFS_POWER_STATE_SELECT, 8'h02, "power reg reset");
    rd_chk(`OFS_CONVERSION_TRIGGER, 8'h00, "conv reg reset");
    $display("test reset_values finished");
  endtask

  task automatic t_wake_conversion();
    wr(`OFS_CONVERSION_TRIGGER, 8'hff);
    repeat (12) @(negedge clk);
    check({6'h0, power_state}, 8'h02, "field during wakeup");
    check({7'h0, conv_go}, 8'h00, "held during wakeup");
    wait_ev(0, 200, n);
    check({7'h0, (n >= `WAKE_CYCLES - 12) && (n <= `WAKE_CYCLES - 6)}, 8'h01, "conversion after wakeup");
    check({1'b0, result_slot_select, 2'h0, conversion_kind}, 8'h73, "stored fields");
    repeat (2) @(negedge clk);
    check({6'h0, power_state}, 8'h00, "normal after wakeup");
    check({6'h0, analog_en, regulator_en}, 8'h03, "normal enables");
    wait_ev(0, 40, n);
    check({7'h0, n == -1}, 8'h01, "single execution");
    rd_chk(`OFS_CONVERSION_TRIGGER, 8'h73, "unused bits");
    $display("test wake_conversion finished");
  endtask

  task automatic t_slots_kinds();
    for (int i = 0; i < 8; i++) begin
      wr(`OFS_CONVERSION_TRIGGER, {1'b0, i[2:0], 2'b00, i[1:0]});
      wait_ev(0, 20, n);
      check({7'h0, n >= 0}, 8'h01, "conversion launched");
      check({5'h0, result_slot_select}, {5'h0, i[2:0]}, "result slot");
      check({6'h0, conversion_kind}, {6'h0, i[1:0]}, "conversion kind");
    end
    $display("test slots_kinds finished");
  endtask

  task automatic t_launch_range();
    logic [6:0] addrs [4] = '{7'h39, 7'h6f, 7'h3a, 7'h6e};
    for (int i = 0; i < 4; i++) begin
      wr(`OFS_SEQUENCE_LAUNCH, {1'b0, addrs[i]});
      wait_ev(1, 20, n);
      check({7'h0, n >= 0}, {7'h0, i >= 2}, "launch accepted");
      if (i >= 2) check({1'b0, sequence_entry_address}, {1'b0, addrs[i]}, "entry address");
    end
    check({7'h0, seq_running}, 8'h01, "sequence running");
    $display("test launch_range finished");
  endtask

  task automatic t_jump();
    @(posedge clk);
    seq_jump <= 1'b1;
    seq_jump_addr <= 7'h42;
    @(posedge clk);
    seq_jump <= 1'b0;
    wait_ev(1, 5, n);
    check({7'h0, n >= 0}, 8'h01, "jump issued");
    check({1'b0, sequence_entry_address}, 8'h42, "jump target");
    check({7'h0, seq_running}, 8'h01, "still running");
    $display("test jump finished");
  endtask

  task automatic t_powerdown_halt();
    wr(`OFS_POWER_STATE_SELECT, 8'h01);
    wait_ev(2, 20, n);
    check({7'h0, n >= 0}, 8'h01, "done flag on halt");
    repeat (2) @(negedge clk);
    check({7'h0, seq_running}, 8'h00, "sequencer halted");
    check({6'h0, power_state}, 8'h01, "standby field");
    check({6'h0, analog_en, regulator_en}, 8'h01, "standby enables");
    $display("test powerdown_halt finished");
  endtask

  task automatic t_standby_launch();
    wr(`OFS_SEQUENCE_LAUNCH, 8'h50);
    wait_ev(1, 200, n);
    check({7'h0, n >= 25}, 8'h01, "launch after wakeup");
    check({1'b0, sequence_entry_address}, 8'h50, "standby entry");
    $display("test standby_launch finished");
  endtask

  task automatic t_abort();
    @(posedge clk);
    conv_busy <= 1'b1;
    wr(`OFS_FILTER_SETUP, 8'hff);
    wait_ev(3, 20, n);
    check({7'h0, n >= 0}, 8'h01, "write aborts conversion");
    @(posedge clk);
    conv_busy <= 1'b0;
    rd_chk(`OFS_FILTER_SETUP, 8'h3f, "filter unused bits");
    $display("test abort finished");
  endtask

  task automatic t_reset_cmd();
    wr(`OFS_POWER_STATE_SELECT, 8'h03);
    repeat (12) @(negedge clk);
    check({6'h0, power_state}, 8'h02, "self clear to sleep");
    check({6'h0, analog_en, regulator_en}, 8'h00, "sleep after reset");
    rd_chk(`OFS_FILTER_SETUP, 8'h00, "filter restored");
    rd_chk(`OFS_POWER_STATE_SELECT, 8'h02, "field reads sleep");
    rd_chk(7'h20, 8'h00, "unmapped read");
    $display("test reset_cmd finished");
  endtask

  // Calibration start from sleep with abort, then delay start from standby
  task automatic t_cal_delay();
    @(posedge clk);
    cal_busy <= 1'b1;
    wr(`OFS_CALIBRATION_TRIGGER, 8'hfd);
    wait_ev(3, 20, n);
    check({7'h0, n >= 0}, 8'h01, "write aborts calibration");
    @(posedge clk);
    cal_busy <= 1'b0;
    wait_ev(4, 200, n);
    check({7'h0, n >= `WAKE_CYCLES - 6}, 8'h01, "calibration after wakeup");
    check({5'h0, cal_type}, 8'h05, "stored calibration type");
    rd_chk(`OFS_CALIBRATION_TRIGGER, 8'h05, "calibration unused bits");
    wr(`OFS_POWER_STATE_SELECT, 8'h01);
    wr(`OFS_DELAY_LAUNCH, 8'h5a);
    wait_ev(5, 200, n);
    check({7'h0, n >= `WAKE_CYCLES}, 8'h01, "delay after wakeup");
    rd_chk(`OFS_DELAY_LAUNCH, 8'h00, "delay unused bits");
    $display("test cal_delay finished");
  endtask

  // Watchdog well beyond the expected run length
  initial begin
    #2000000;
    mismatches++;
    $display("[ERR] %0t watchdog expired", $time);
    results();
  end

  // Main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    rstn = 1'b0;
    ce = 1'b1;
    conv_busy = 1'b0;
    cal_busy = 1'b0;
    seq_jump = 1'b0;
    seq_finished = 1'b0;
    seq_jump_addr = 7'h00;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (8) @(negedge clk);
    t_reset_values();
    t_wake_conversion();
    t_slots_kinds();
    t_launch_range();
    t_jump();
    t_powerdown_halt();
    t_standby_launch();
    t_abort();
    t_reset_cmd();
    t_cal_delay();
    results();
  end
endmodule

// ### tb/spi_host_model.sv
// Host side of the serial control port: mode-0 frames on a clock that stops between frames
`timescale 1ns/1ps
module spi_host_model (
  output logic     sclk,
  output logic     csb,
  output logic     sdi,
  input  wire logic sdo
);
  realtime last_end;

  // Idle: frame deselected, clock parked low
  initial begin
    sclk = 1'b0;
    csb = 1'b1;
    sdi = 1'b1;
    last_end = 0;
  end

  // One access per frame: control byte then data byte, MSB first, sampled on rising edges
  task automatic xfer(input logic rd, input logic [6:0] addr, input logic [7:0] wdata,
                      output logic [7:0] rdata);
    logic [15:0] word;
    word = {rd, addr, wdata};
    rdata = 8'h00;
    while ($realtime < last_end + 400.0) #1; // Spacing of at least 10 core cycles
    csb = 1'b0;
    #203; // Core must see the frame open before the first edge
    for (int i = 15; i >= 0; i--) begin
      sdi = word[i];
      #16 sclk = 1'b1;
      if (i < 8) rdata[i[2:0]] = sdo;
      #16 sclk = 1'b0;
    end
    csb = 1'b1;
    sdi = ~sdi; // Released line never shows its last bit
    last_end = $realtime;
  endtask
endmodule
